// [sim/clock_source_model.sv]
`timescale 1ns/1ps

module clock_source_model #(
	parameter int RC_HALF_NS = 130,
	parameter int XT_HALF_NS = 170
) (
	// Oscillator enables from the block
	input  wire logic rc_osc_enable,
	input  wire logic crystal_osc_enable,
	// Bench drives an external clock onto the crystal pin
	input  wire logic ext_clock_on,
	// Clock pins
	output logic      rc_clk_pin,
	output logic      xin_pin
);
	// RC near 3.8 MHz, well above the 100 kHz floor; idles low when off
	initial begin
		rc_clk_pin = 1'b0;
		forever begin
			wait (rc_osc_enable === 1'b1);
			#(RC_HALF_NS) rc_clk_pin = 1'b1;
			#(RC_HALF_NS) rc_clk_pin = 1'b0;
		end
	end

	// Phase restarts on enable so the start-up edge count is exact
	initial begin
		xin_pin = 1'b0;
		forever begin
			wait (crystal_osc_enable === 1'b1 || ext_clock_on === 1'b1);
			#(XT_HALF_NS) xin_pin = 1'b1;
			#(XT_HALF_NS) xin_pin = 1'b0;
		end
	end
endmodule

// [sim/clock_source_prescaler_ctrl_bench.sv]
`timescale 1ns/1ps
`include "clk_ctrl_params.svh"

module clock_source_prescaler_ctrl_bench;
	// Bus side
	logic        sys_clk;
	logic        reset;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	// Pins and observed outputs
	logic        pin_rst_n;
	logic        xin_pin;
	logic        rc_clk_pin;
	logic        sleep_mode;
	logic        ext_on;
	logic        xt_en;
	logic        rc_en;
	logic        cpu_clk_en;
	logic        slow_32k_clock;
	logic [14:0] low_div_value;
	// Bench state
	int          miscompares;
	int          num_checks;
	logic [31:0] n_cpu = 32'h0;
	logic [31:0] n_slow = 32'h0;
	logic        cpu_prev;
	logic [31:0] rd;
	logic [31:0] c0;
	logic [31:0] c1;
	logic        err;

	// Short warm-up keeps the run brief
	clock_source_prescaler_ctrl #(.WARMUP_CYCLES(4))
		i_clock_source_prescaler_ctrl (
		.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_reset_pin_n(pin_rst_n), .xin_pin(xin_pin),
		.rc_clk_pin(rc_clk_pin), .sleep_mode(sleep_mode),
		.crystal_osc_enable(xt_en), .rc_osc_enable(rc_en),
		.cpu_clk_en(cpu_clk_en), .slow_32k_clock(slow_32k_clock),
		.low_div_value(low_div_value));

	clock_source_model i_clock_source_model (
		.rc_osc_enable(rc_en), .crystal_osc_enable(xt_en),
		.ext_clock_on(ext_on), .rc_clk_pin(rc_clk_pin), .xin_pin(xin_pin));

	// 25 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic chk(input string name, input logic [31:0] exp,
			input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Pulse counters; a two-cycle pulse would be a clipped CPU period
	always @(posedge sys_clk) begin
		cpu_prev <= cpu_clk_en;
		if (cpu_clk_en === 1'b1) begin
			n_cpu <= n_cpu + 32'h1;
			chk("cpu pulse run", 32'h0, {31'h0, cpu_prev});
		end
		if (slow_32k_clock === 1'b1) begin
			n_slow <= n_slow + 32'h1;
		end
	end

	// One transfer, then an idle cycle so psel is never set twice at once
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		// Callers may arrive on a pin edge; setup starts on a clock edge
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		// The loop is unbounded, only the watchdog ends a lost answer; exactly one access cycle, with no wait state, is checked
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		chk("wait states", 32'h1, 32'(n));
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rchk(input string name, input logic [7:0] a,
			input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(name, exp, rd);
	endtask

	task automatic pin_edge(input logic on_xin);
		if (on_xin) begin
			@(posedge xin_pin);
		end else begin
			@(posedge rc_clk_pin);
		end
	endtask

	// Pulses over n pin edges; output latency stays under one pin period
	task automatic meas(input logic on_xin, input int n);
		logic [31:0] a;
		logic [31:0] b;
		pin_edge(on_xin);
		a = n_cpu;
		b = n_slow;
		repeat (n) pin_edge(on_xin);
		c0 = n_cpu - a;
		c1 = n_slow - b;
	endtask

	task automatic wait_low();
		int n;
		n = 0;
		while (low_div_value === 15'h0 && n < 400) begin
			@(posedge sys_clk);
			n++;
		end
		chk("low running", 32'h1, {31'h0, low_div_value !== 15'h0});
	endtask

	task automatic t_reset();
		rchk("ctrl", `OFS_CLK_CTRL, 32'h9);
		rchk("clear bit", `OFS_PRESCALER, 32'h0);
		rchk("unmapped", 8'h18, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		chk("xtal enable", 32'h0, {31'h0, xt_en});
		chk("rc enable", 32'h1, {31'h0, rc_en});
	endtask

	task automatic t_rc();
		for (int k = 0; k < 5; k++) begin
			apb(1'b1, `OFS_CPU_DIV, 32'(k));
			meas(1'b0, 16);
			meas(1'b0, 32);
			chk("cpu ticks", 32'd32 >> k, c0);
		end
		apb(1'b1, `OFS_CPU_DIV, {29'h0, clk_ctrl_pkg::DIV_1});
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, `OFS_TRIM_COARSE, (32'h1 << k) - 32'h1);
			meas(1'b0, 16);
			meas(1'b0, 32);
			chk("slow ticks", 32'd32 >> k, c1);
		end
		apb(1'b1, `OFS_CLK_CTRL, 32'h41);
		meas(1'b0, 16);
		meas(1'b0, 32);
		chk("cpu on prescaler", 32'd4, c0);
		apb(1'b1, `OFS_CLK_CTRL, 32'h1);
	endtask

	task automatic t_clear();
		wait_low();
		apb(1'b1, `OFS_PRESCALER, 32'h0);
		chk("zero write", 32'h1, {31'h0, low_div_value !== 15'h0});
		apb(1'b1, `OFS_PRESCALER, 32'h1);
		chk("cleared", 32'h0, {17'h0, low_div_value});
		rchk("clear bit", `OFS_PRESCALER, 32'h0);
	endtask

	task automatic t_xtal();
		logic [31:0] a;
		logic [31:0] b;
		wait_low();
		apb(1'b1, `OFS_CLK_CTRL, 32'h3);
		b = n_slow;
		// The enable output is launched one edge after the write lands
		@(posedge sys_clk);
		chk("xtal enable", 32'h1, {31'h0, xt_en});
		chk("low on start", 32'h0, {17'h0, low_div_value});
		repeat (2) @(posedge xin_pin);
		rchk("ctrl warm", `OFS_CLK_CTRL, 32'hb);
		repeat (6) @(posedge xin_pin);
		repeat (6) @(posedge sys_clk);
		chk("masked ticks", 32'd4, n_slow - b);
		rchk("ctrl warm done", `OFS_CLK_CTRL, 32'h3);
		meas(1'b1, 16);
		chk("xtal slow ticks", 32'd16, c1);
		apb(1'b1, `OFS_CLK_CTRL, 32'h43);
		apb(1'b1, `OFS_CLK_CTRL, 32'h42);
		@(posedge sys_clk);
		chk("rc enable", 32'h0, {31'h0, rc_en});
		meas(1'b1, 8);
		apb(1'b0, `OFS_STATUS, 32'h0);
		a = rd;
		meas(1'b1, 16);
		chk("cpu on xtal", 32'd16, c0);
		apb(1'b0, `OFS_STATUS, 32'h0);
		chk("high halted", {24'h0, a[7:0]}, {24'h0, rd[7:0]});
		apb(1'b1, `OFS_CLK_CTRL, 32'h40);
		repeat (8) @(posedge sys_clk);
		a = n_cpu + n_slow;
		repeat (200) @(posedge sys_clk);
		chk("all off", a, n_cpu + n_slow);
		apb(1'b1, `OFS_CLK_CTRL, 32'h1);
	endtask

	task automatic t_ext();
		ext_on <= 1'b1;
		apb(1'b1, `OFS_CLK_CTRL, 32'h21);
		apb(1'b1, `OFS_CLK_CTRL, 32'h20);
		meas(1'b1, 16);
		meas(1'b1, 32);
		chk("ext cpu ticks", 32'd16, c0);
		chk("ext slow ticks", 32'd2, c1);
		apb(1'b1, `OFS_CLK_CTRL, 32'h62);
		meas(1'b1, 16);
		meas(1'b1, 64);
		chk("ext slow cpu", 32'd4, c0);
		apb(1'b1, `OFS_CLK_CTRL, 32'h21);
		apb(1'b1, `OFS_CLK_CTRL, 32'h1);
		ext_on <= 1'b0;
	endtask

	// Sync latency of the pins is three edges, so four are allowed
	task automatic t_sleep();
		apb(1'b1, `OFS_CLK_CTRL, 32'h3);
		sleep_mode <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("xtal in sleep", 32'h0, {31'h0, xt_en});
		sleep_mode <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rchk("ctrl after sleep", `OFS_CLK_CTRL, 32'h9);
		apb(1'b1, `OFS_CLK_CTRL, 32'h63);
		pin_rst_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		pin_rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("xtal after pin", 32'h0, {31'h0, xt_en});
		rchk("ctrl after pin", `OFS_CLK_CTRL, 32'h9);
		wait_low();
		reset <= 1'b1;
		repeat (6) @(posedge sys_clk);
		chk("low in reset", 32'h0, {17'h0, low_div_value});
		reset <= 1'b0;
		@(posedge sys_clk);
		rchk("ctrl after reset", `OFS_CLK_CTRL, 32'h9);
	endtask

	task automatic conclude();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hf;
		pin_rst_n = 1'b1;
		sleep_mode = 1'b0;
		ext_on = 1'b0;
		miscompares = 0;
		num_checks = 0;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		t_reset();
		t_rc();
		t_clear();
		t_xtal();
		t_ext();
		t_sleep();
		conclude();
	end

	// Whole run needs about 5000 cycles
	initial begin
		repeat (60000) @(posedge sys_clk);
		miscompares++;
		conclude();
	end
endmodule

// [src/clk_ctrl_params.svh]
// How it works
// - Crystal clock is masked for its first 32768 cycles after start.
// - Reset, pin reset or sleep clear crystal enable and set warm-up flag.
// - Warm-up flag clears itself after 32768 crystal cycles.
// - Software sets crystal enable to start it, clears it to stop it.
// - Sleep entry stops the crystal whatever software programmed.
// - External clock on the crystal pin is divided by two.
// - External select bit makes the crystal pin the clock source.
// - In external mode the crystal cannot serve as clock source.
// - Power-up, pin reset or sleep exit select the RC oscillator.
// - Slow select picks crystal if usable, else high prescaler 32 kHz tap.
// - CPU clock source changes without glitches or short pulses.
// - Fast CPU clock divides by 1, 2, 4, 8 or 16.
// - High prescaler has eight stages, low prescaler fifteen.
// - High prescaler runs only from RC or external clock.
// - Low prescaler runs from crystal if usable, else high prescaler.
// - Writing the clear bit resets the low prescaler synchronously.
// - Setting crystal enable clears the low prescaler.
// - Global reset clears both prescaler chains.
// - Clear bit acts on a written one and always reads zero.
// - Trim-driven decoder picks the high prescaler tap near 32 kHz.
// - Crystal enable is bit 1 of clock control, cleared by reset, sleep.
`ifndef CLK_CTRL_PARAMS_SVH
`define CLK_CTRL_PARAMS_SVH

// Register byte offsets
`define OFS_CLK_CTRL      8'h00
`define OFS_PRESCALER     8'h04
`define OFS_TRIM_COARSE   8'h08
`define OFS_TRIM_FINE     8'h0c
`define OFS_CPU_DIV       8'h10
`define OFS_STATUS        8'h14

// Clock control field positions, then the prescaler clear bit
`define BIT_RC_ON         0
`define BIT_XTAL_ON       1
`define BIT_WARMUP        3
`define BIT_EXT_SEL       5
`define BIT_SLOW_SEL      6
`define BIT_LP_CLEAR      0

// Reset values
`define RST_TRIM_COARSE   5'h01
`define RST_TRIM_FINE     6'h00

// Crystal cycles masked during start-up
`define WARMUP_XTAL_CYCLES 32768

`endif

// [src/clk_ctrl_pkg.sv]
package clk_ctrl_pkg;

	// CPU fast clock division codes
	typedef enum logic [2:0] {
		DIV_1  = 3'h0,
		DIV_2  = 3'h1,
		DIV_4  = 3'h2,
		DIV_8  = 3'h3,
		DIV_16 = 3'h4
	} cpu_div_e;

endpackage

// [src/clock_source_prescaler_ctrl.sv]
`timescale 1ns/1ps
`include "clk_ctrl_params.svh"

module clock_source_prescaler_ctrl #(
	parameter int unsigned WARMUP_CYCLES = `WARMUP_XTAL_CYCLES
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Pins and power mode
	input  wire logic        external_reset_pin_n,
	input  wire logic        xin_pin,
	input  wire logic        rc_clk_pin,
	input  wire logic        sleep_mode,
	// Oscillator enables
	output logic             crystal_osc_enable,
	output logic             rc_osc_enable,
	// Clock enables and divider state
	output logic             cpu_clk_en,
	output logic             slow_32k_clock,
	output logic      [14:0] low_div_value
);

	localparam logic [15:0] WARMUP_LAST = 16'(WARMUP_CYCLES - 1);

	// Register address decode, used by read and write paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	// Division code to terminal count of the fast divider
	function automatic logic [3:0] div_limit(input logic [2:0] code);
		unique case (code)
			clk_ctrl_pkg::DIV_1:  div_limit = 4'h0;
			clk_ctrl_pkg::DIV_2:  div_limit = 4'h1;
			clk_ctrl_pkg::DIV_4:  div_limit = 4'h3;
			clk_ctrl_pkg::DIV_8:  div_limit = 4'h7;
			default:              div_limit = 4'hf;
		endcase
	endfunction

	// Tap near 32 kHz: log2 of coarse plus one, three more in high range
	function automatic logic [2:0] tap_sel(input logic [4:0] coarse);
		logic [2:0] lg;
		lg = 3'h0;
		if (coarse[3:0] >= 4'h1)
			lg = 3'h1;
		if (coarse[3:0] >= 4'h3)
			lg = 3'h2;
		if (coarse[3:0] >= 4'h7)
			lg = 3'h3;
		if (coarse[3:0] == 4'hf)
			lg = 3'h4;
		if (coarse[4])
			tap_sel = (lg == 3'h4) ? 3'h7 : 3'(lg + 3'h3);
		else
			tap_sel = lg;
	endfunction

	// Synchronisers and pin edge history
	logic [1:0] rst_pin_sync_q;
	logic [1:0] xin_sync_q;
	logic [1:0] rc_sync_q;
	logic       xin_prev_q;
	logic       rc_prev_q;
	logic       sleep_prev_q;

	// Control registers
	logic       rc_osc_on_q;
	logic       crystal_osc_on_q;
	logic       crystal_warmup_flag_q;
	logic       external_clock_select_q;
	logic       cpu_slow_select_q;
	logic [4:0] trim_coarse_q;
	logic [5:0] trim_fine_q;
	logic [2:0] cpu_div_q;

	// Datapath state
	logic [15:0] warmup_cnt_q;
	logic        ext_half_q;
	logic [7:0]  high_div_q;
	logic [14:0] low_div_q;
	logic [3:0]  fast_cnt_q;
	logic [3:0]  fast_lim_q;
	logic        slow_path_q;

	// Registered outputs
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        crystal_osc_enable_q;
	logic        rc_osc_enable_q;
	logic        cpu_clk_en_q;
	logic        slow_32k_clock_q;

	// Pin reset and sleep events
	wire pin_reset   = ~rst_pin_sync_q[1];
	wire sleep_entry = sleep_mode & ~sleep_prev_q;
	wire sleep_exit  = ~sleep_mode & sleep_prev_q;
	wire force_cold  = pin_reset | sleep_mode;

	// APB decode
	wire setup_ph  = psel & ~penable;
	wire wr_en     = psel & penable & pready_q & pwrite & pstrb[0];
	wire ctrl_hit  = hit(paddr, `OFS_CLK_CTRL);
	wire pre_hit   = hit(paddr, `OFS_PRESCALER);
	wire crs_hit   = hit(paddr, `OFS_TRIM_COARSE);
	wire fin_hit   = hit(paddr, `OFS_TRIM_FINE);
	wire div_hit   = hit(paddr, `OFS_CPU_DIV);
	wire sts_hit   = hit(paddr, `OFS_STATUS);
	wire any_hit   = ctrl_hit | pre_hit | crs_hit | fin_hit | div_hit
	               | sts_hit;
	wire wr_ctrl   = wr_en & ctrl_hit;
	wire xtal_set  = wr_ctrl & pwdata[`BIT_XTAL_ON] & ~crystal_osc_on_q
	               & ~force_cold;
	wire lp_clear  = (wr_en & pre_hit & pwdata[`BIT_LP_CLEAR])
	               | xtal_set;

	// Read mux; the clear bit is never stored, so it reads zero
	wire [7:0] ctrl_rd = {1'b0, cpu_slow_select_q, external_clock_select_q,
	                      1'b0, crystal_warmup_flag_q, 1'b0,
	                      crystal_osc_on_q, rc_osc_on_q};
	wire [31:0] rd_mux =
		ctrl_hit ? {24'h000000, ctrl_rd} :
		crs_hit  ? {27'h0000000, trim_coarse_q} :
		fin_hit  ? {26'h0000000, trim_fine_q} :
		div_hit  ? {29'h00000000, cpu_div_q} :
		sts_hit  ? {9'h000, low_div_q, high_div_q} :
		32'h00000000;

	// Source ticks from pin edges
	wire xin_rise  = xin_sync_q[1] & ~xin_prev_q;
	wire rc_rise   = rc_sync_q[1] & ~rc_prev_q;
	wire xtal_run  = crystal_osc_on_q & ~external_clock_select_q;
	wire xtal_tick = xin_rise & xtal_run;
	// Masked until warm-up ends, so no early pulse is passed on
	wire xtal_use  = xtal_tick & ~crystal_warmup_flag_q;
	// Every second rising edge of the pin in external mode
	wire ext_tick  = xin_rise & external_clock_select_q & ext_half_q;
	wire rc_tick   = rc_rise & rc_osc_on_q & ~external_clock_select_q;
	// High prescaler only ever sees RC or external ticks
	wire fast_tick = external_clock_select_q ? ext_tick : rc_tick;

	// Carry taps of the eight-stage high prescaler
	// The decoder never picks past tap 7, so the last carry is not built
	logic [7:0] tap_tick;
	assign tap_tick[0] = fast_tick;
	genvar gi;
	generate
		for (gi = 1; gi < 8; gi++) begin : g_tap
			assign tap_tick[gi] = fast_tick & (&high_div_q[gi-1:0]);
		end
	endgenerate

	// Decoder picks the tap nearest 32 kHz from the trim setting
	wire [2:0] tap_idx   = tap_sel(trim_coarse_q);
	wire       hp32_tick = tap_tick[tap_idx];
	// Low prescaler input: crystal when it runs, else the decoded tap
	wire       lp_tick   = xtal_run ? xtal_use : hp32_tick;
	// Slow CPU source follows the same choice
	wire       slow_tick = xtal_run ? xtal_use : hp32_tick;

	// Fast CPU divider
	wire fast_end  = fast_tick & (fast_cnt_q == fast_lim_q);
	wire fast_div  = fast_end;
	// Source may only change when neither path is mid-pulse
	wire sel_quiet = ~fast_tick & ~slow_tick & (fast_cnt_q == 4'h0);
	wire cpu_tick  = slow_path_q ? slow_tick : fast_div;

	// Synchronisers: second stage is the only reader of the first
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rst_pin_sync_q <= 2'h3;
			xin_sync_q     <= 2'h0;
			rc_sync_q      <= 2'h0;
			xin_prev_q     <= 1'b0;
			rc_prev_q      <= 1'b0;
			sleep_prev_q   <= 1'b0;
		end else begin
			rst_pin_sync_q <= {rst_pin_sync_q[0], external_reset_pin_n};
			xin_sync_q     <= {xin_sync_q[0], xin_pin};
			rc_sync_q      <= {rc_sync_q[0], rc_clk_pin};
			xin_prev_q     <= xin_sync_q[1];
			rc_prev_q      <= rc_sync_q[1];
			sleep_prev_q   <= sleep_mode;
		end
	end

	// APB answer: one access cycle, unmapped address gives pslverr
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end else begin
			pready_q  <= setup_ph;
			pslverr_q <= setup_ph & ~any_hit;
			if (setup_ph)
				prdata_q <= rd_mux;
		end
	end

	// Crystal enable: hardware clear wins over a software set
	always_ff @(posedge sys_clk) begin
		if (reset)
			crystal_osc_on_q <= 1'b0;
		else if (force_cold | sleep_entry)
			crystal_osc_on_q <= 1'b0;
		else if (wr_ctrl)
			crystal_osc_on_q <= pwdata[`BIT_XTAL_ON];
	end

	// RC enable, external and slow select
	always_ff @(posedge sys_clk) begin
		if (reset | pin_reset | sleep_exit) begin
			rc_osc_on_q             <= 1'b1;
			external_clock_select_q <= 1'b0;
			cpu_slow_select_q       <= 1'b0;
		end else if (sleep_mode) begin
			rc_osc_on_q             <= 1'b0;
		end else if (wr_ctrl) begin
			rc_osc_on_q             <= pwdata[`BIT_RC_ON];
			external_clock_select_q <= pwdata[`BIT_EXT_SEL];
			cpu_slow_select_q       <= pwdata[`BIT_SLOW_SEL];
		end
	end

	// Trim and divider code registers
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			trim_coarse_q <= `RST_TRIM_COARSE;
			trim_fine_q   <= `RST_TRIM_FINE;
			cpu_div_q     <= clk_ctrl_pkg::DIV_1;
		end else if (wr_en) begin
			if (crs_hit)
				trim_coarse_q <= pwdata[4:0];
			if (fin_hit)
				trim_fine_q <= pwdata[5:0];
			if (div_hit)
				cpu_div_q <= pwdata[2:0];
		end
	end

	// Warm-up flag and its crystal cycle counter
	always_ff @(posedge sys_clk) begin
		if (reset | force_cold | sleep_entry | ~xtal_run) begin
			crystal_warmup_flag_q <= 1'b1;
			warmup_cnt_q          <= 16'h0000;
		end else if (xtal_tick & crystal_warmup_flag_q) begin
			if (warmup_cnt_q == WARMUP_LAST)
				crystal_warmup_flag_q <= 1'b0;
			warmup_cnt_q <= warmup_cnt_q + 16'h0001;
		end
	end

	// External clock halving phase
	always_ff @(posedge sys_clk) begin
		if (reset | ~external_clock_select_q)
			ext_half_q <= 1'b0;
		else if (xin_rise)
			ext_half_q <= ~ext_half_q;
	end

	// Prescaler chains; global reset clears both
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			high_div_q <= 8'h00;
			low_div_q  <= 15'h0000;
		end else begin
			if (fast_tick)
				high_div_q <= high_div_q + 8'h01;
			if (lp_clear)
				low_div_q <= 15'h0000;
			else if (lp_tick)
				low_div_q <= low_div_q + 15'h0001;
		end
	end

	// Fast divider; a new code only lands at a period boundary
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			fast_cnt_q <= 4'h0;
			fast_lim_q <= 4'h0;
		end else if (fast_end) begin
			fast_cnt_q <= 4'h0;
			fast_lim_q <= div_limit(cpu_div_q);
		end else if (fast_tick) begin
			fast_cnt_q <= fast_cnt_q + 4'h1;
		end else if (fast_cnt_q == 4'h0) begin
			fast_lim_q <= div_limit(cpu_div_q);
		end
	end

	// Path select follows the register only between pulses
	always_ff @(posedge sys_clk) begin
		if (reset)
			slow_path_q <= 1'b0;
		else if (sel_quiet)
			slow_path_q <= cpu_slow_select_q;
	end

	// Output flops
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			crystal_osc_enable_q <= 1'b0;
			rc_osc_enable_q      <= 1'b0;
			cpu_clk_en_q         <= 1'b0;
			slow_32k_clock_q     <= 1'b0;
		end else begin
			crystal_osc_enable_q <= xtal_run & ~sleep_mode;
			rc_osc_enable_q      <= rc_osc_on_q & ~sleep_mode;
			cpu_clk_en_q         <= cpu_tick;
			slow_32k_clock_q     <= lp_tick;
		end
	end

	assign prdata             = prdata_q;
	assign pready             = pready_q;
	assign pslverr            = pslverr_q;
	assign crystal_osc_enable = crystal_osc_enable_q;
	assign rc_osc_enable      = rc_osc_enable_q;
	assign cpu_clk_en         = cpu_clk_en_q;
	assign slow_32k_clock     = slow_32k_clock_q;
	assign low_div_value      = low_div_q;

	// Assertions
	property p_warmup_mask;
		@(posedge sys_clk) disable iff (reset)
		crystal_warmup_flag_q |-> !xtal_use;
	endproperty
	a_warmup_mask: assert property (p_warmup_mask)
		else $error("crystal tick passed during warm-up");

	property p_warmup_end;
		@(posedge sys_clk) disable iff (reset)
		(xtal_tick && crystal_warmup_flag_q && warmup_cnt_q == WARMUP_LAST
		 && !force_cold && !sleep_entry) |=> !crystal_warmup_flag_q;
	endproperty
	a_warmup_end: assert property (p_warmup_end)
		else $error("warm-up flag did not clear at last cycle");

	property p_sleep_cold;
		@(posedge sys_clk) disable iff (reset)
		sleep_mode |=> !crystal_osc_on_q && crystal_warmup_flag_q
		               && !crystal_osc_enable;
	endproperty
	a_sleep_cold: assert property (p_sleep_cold)
		else $error("sleep did not stop crystal");

	property p_xtal_write;
		@(posedge sys_clk) disable iff (reset)
		(wr_ctrl && !force_cold && !sleep_entry)
		|=> crystal_osc_on_q == $past(pwdata[`BIT_XTAL_ON]);
	endproperty
	a_xtal_write: assert property (p_xtal_write)
		else $error("crystal enable did not follow write");

	property p_ext_half;
		@(posedge sys_clk) disable iff (reset)
		ext_tick |=> !ext_tick ##1 !ext_half_q;
	endproperty
	a_ext_half: assert property (p_ext_half)
		else $error("external clock not halved");

	property p_ext_no_xtal;
		@(posedge sys_clk) disable iff (reset)
		external_clock_select_q |-> !xtal_use && !xtal_tick;
	endproperty
	a_ext_no_xtal: assert property (p_ext_no_xtal)
		else $error("crystal used in external mode");

	property p_pin_rc;
		@(posedge sys_clk) disable iff (reset)
		pin_reset |=> rc_osc_on_q && !external_clock_select_q
		              && !cpu_slow_select_q && !crystal_osc_on_q;
	endproperty
	a_pin_rc: assert property (p_pin_rc)
		else $error("pin reset did not select RC");

	property p_lp_clear;
		@(posedge sys_clk) disable iff (reset)
		lp_clear |=> low_div_q == 15'h0000;
	endproperty
	a_lp_clear: assert property (p_lp_clear)
		else $error("low prescaler not cleared");

	property p_clear_reads_zero;
		@(posedge sys_clk) disable iff (reset)
		(setup_ph && pre_hit) |=> prdata == 32'h00000000;
	endproperty
	a_clear_reads_zero: assert property (p_clear_reads_zero)
		else $error("clear bit read back nonzero");

	property p_all_off;
		@(posedge sys_clk) disable iff (reset)
		(!rc_osc_on_q && !crystal_osc_on_q && !external_clock_select_q)
		|=> !cpu_clk_en && !slow_32k_clock;
	endproperty
	a_all_off: assert property (p_all_off)
		else $error("clock edge with all sources off");

	property p_hp_source;
		@(posedge sys_clk) disable iff (reset)
		(!rc_osc_on_q && !external_clock_select_q) |=> $stable(high_div_q);
	endproperty
	a_hp_source: assert property (p_hp_source)
		else $error("high prescaler ran without RC or external");

endmodule
